// >>> src/sched_params.svh
`ifndef SCHED_PARAMS_SVH
`define SCHED_PARAMS_SVH

// ***************************************************
// timing
// ***************************************************
`define CLK_FREQ_HZ 25000000
`define FOUR_WAIT_TIME_MS 20
`define FOUR_WAIT_CYCLES (`FOUR_WAIT_TIME_MS * `CLK_FREQ_HZ / 1000)
`define WAIT_CNT_W 20

// ***************************************************
// codes and field positions
// ***************************************************
`define START_SIGNAL_ERR_CODE 8'h02
`define SCHED_RESET 4'h0
`define VALVE1_MIN 4'h1
`define VALVE1_MAX 4'h7
`define VALVE2_MIN 4'h8
`define VALVE2_MAX 4'hf
`define SYNC_W 9
`define SYNC_WEIGHT_LSB 0
`define SYNC_PARITY_BIT 4
`define SYNC_ERR_RESET_BIT 5
`define SYNC_PARITY_SW_BIT 6
`define SYNC_FOUR_SW_BIT 7
`define SYNC_PANEL_SW_BIT 8

`endif

// >>> src/sched_pkg.sv
package sched_pkg;
  typedef struct packed {
    logic [3:0] weight;
    logic parity;
  } start_pins_t;

  typedef struct packed {
    logic parity_check_switch;
    logic four_schedule_switch;
    logic panel_schedule_switch;
  } switches_t;

  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_active,
    st_reject
  } dec_state_t;
endpackage : sched_pkg

// >>> src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : pin_sync

// >>> src/weld_start_schedule_decoder.sv
`timescale 1ns/1ps
`include "sched_params.svh"
module weld_start_schedule_decoder #(
  parameter int unsigned WAIT_CYCLES = `FOUR_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire sched_pkg::start_pins_t start_pins,
  input wire logic error_reset_pin,
  input wire sched_pkg::switches_t switches,
  input wire logic [3:0] panel_schedule,
  output logic [3:0] schedule,
  output logic start_pulse,
  output logic valve1,
  output logic valve2,
  output logic error,
  output logic [7:0] error_code
);
  import sched_pkg::*;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [`SYNC_W-1:0] pins_raw;
  logic [`SYNC_W-1:0] pins_s;
  logic [3:0] weight_s;
  logic parity_s;
  logic err_reset_s;
  logic parity_sw_s;
  logic four_sw_s;
  logic panel_sw_s;

  assign pins_raw = {switches.panel_schedule_switch, switches.four_schedule_switch,
                     switches.parity_check_switch, error_reset_pin,
                     start_pins.parity, start_pins.weight};

  pin_sync #(.W(`SYNC_W)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign weight_s = pins_s[`SYNC_WEIGHT_LSB +: 4];
  assign parity_s = pins_s[`SYNC_PARITY_BIT];
  assign err_reset_s = pins_s[`SYNC_ERR_RESET_BIT];
  assign parity_sw_s = pins_s[`SYNC_PARITY_SW_BIT];
  assign four_sw_s = pins_s[`SYNC_FOUR_SW_BIT];
  assign panel_sw_s = pins_s[`SYNC_PANEL_SW_BIT];

  // ***************************************************
  // decode helpers
  // ***************************************************
  logic any_start;
  logic parity_fail;
  logic [3:0] lowest_sched;

  assign any_start = |weight_s;
  // odd count of five inputs passes, parity ignored when switch off
  assign parity_fail = parity_sw_s && !(^{weight_s, parity_s});

  always_comb begin
    if (weight_s[0]) begin
      lowest_sched = 4'h1;
    end else if (weight_s[1]) begin
      lowest_sched = 4'h2;
    end else if (weight_s[2]) begin
      lowest_sched = 4'h4;
    end else if (weight_s[3]) begin
      lowest_sched = 4'h8;
    end else begin
      lowest_sched = `SCHED_RESET;
    end
  end

  // ***************************************************
  // start sequencer
  // ***************************************************
  dec_state_t state_q;
  dec_state_t state_d;
  logic [`WAIT_CNT_W-1:0] cnt_q;
  logic [`WAIT_CNT_W-1:0] cnt_d;
  logic [3:0] schedule_q;
  logic [3:0] schedule_d;
  logic start_q;
  logic start_d;
  logic valve1_q;
  logic valve1_d;
  logic valve2_q;
  logic valve2_d;
  logic error_q;
  logic error_d;
  logic [7:0] code_q;
  logic [7:0] code_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    schedule_d = schedule_q;
    start_d = 1'b0;
    error_d = error_q;
    code_d = code_q;
    if (err_reset_s) begin
      error_d = 1'b0;
      code_d = 8'h00;
    end
    unique case (state_q)
      st_idle: begin
        if (any_start) begin
          if (panel_sw_s) begin
            schedule_d = panel_schedule;
            start_d = 1'b1;
            state_d = st_active;
          end else if (four_sw_s) begin
            cnt_d = '0;
            state_d = st_wait;
          end else if (parity_fail) begin
            error_d = 1'b1;
            code_d = `START_SIGNAL_ERR_CODE;
            state_d = st_reject;
          end else begin
            schedule_d = weight_s;
            start_d = 1'b1;
            state_d = st_active;
          end
        end
      end
      st_wait: begin
        if (cnt_q == `WAIT_CNT_W'(WAIT_CYCLES - 1)) begin
          if (any_start) begin
            schedule_d = lowest_sched;
            start_d = 1'b1;
            state_d = st_active;
          end else begin
            state_d = st_idle;
          end
        end else begin
          cnt_d = cnt_q + `WAIT_CNT_W'(1);
        end
      end
      st_active: begin
        if (!any_start) begin
          state_d = st_idle;
        end
      end
      st_reject: begin
        if (!any_start) begin
          state_d = st_idle;
        end
      end
    endcase
    valve1_d = (state_d == st_active) && (schedule_d >= `VALVE1_MIN)
               && (schedule_d <= `VALVE1_MAX);
    valve2_d = (state_d == st_active) && (schedule_d >= `VALVE2_MIN)
               && (schedule_d <= `VALVE2_MAX);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
      cnt_q <= '0;
      schedule_q <= `SCHED_RESET;
      start_q <= 1'b0;
      valve1_q <= 1'b0;
      valve2_q <= 1'b0;
      error_q <= 1'b0;
      code_q <= 8'h00;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      schedule_q <= schedule_d;
      start_q <= start_d;
      valve1_q <= valve1_d;
      valve2_q <= valve2_d;
      error_q <= error_d;
      code_q <= code_d;
    end
  end

  assign schedule = schedule_q;
  assign start_pulse = start_q;
  assign valve1 = valve1_q;
  assign valve2 = valve2_q;
  assign error = error_q;
  assign error_code = code_q;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic idle_go;
  assign idle_go = ce && (state_q == st_idle) && any_start && !panel_sw_s && !four_sw_s;

  fifteen_select_a: assert property (idle_go && !parity_fail |=> start_q
    && schedule_q == $past(weight_s) && error_q == ($past(error_q) && !$past(err_reset_s)))
    else $error("binary schedule not selected");
  parity_off_a: assert property (!$past(error_q) && error_q |-> $past(parity_sw_s))
    else $error("error raised with parity check off");
  parity_odd_a: assert property (idle_go && parity_sw_s && (^{weight_s, parity_s})
    |=> start_q && !$rose(error_q))
    else $error("odd parity start rejected");
  parity_error_a: assert property (idle_go && parity_fail |=> error_q && !start_q
    && error_code == `START_SIGNAL_ERR_CODE && state_q == st_reject)
    else $error("even parity not flagged");
  four_lowest_a: assert property (start_q && $past(state_q) == st_wait
    |-> schedule_q == $past(lowest_sched) && $onehot(schedule_q))
    else $error("four mode picked wrong input");
  four_timeout_a: assert property (ce && state_q == st_wait && any_start
    && cnt_q == `WAIT_CNT_W'(WAIT_CYCLES - 1) |=> start_q)
    else $error("four mode start not taken at timeout");
  four_early_a: assert property (start_q && $past(state_q) == st_wait
    |-> $past(cnt_q) == `WAIT_CNT_W'(WAIT_CYCLES - 1))
    else $error("four mode started before wait end");
  valve_one_a: assert property (valve1_q |-> schedule_q >= `VALVE1_MIN
    && schedule_q <= `VALVE1_MAX && !valve2_q)
    else $error("valve1 out of range");
  valve_two_a: assert property (valve2_q |-> schedule_q >= `VALVE2_MIN && !valve1_q)
    else $error("valve2 out of range");
  error_clear_a: assert property (ce && err_reset_s && !(idle_go && parity_fail)
    |=> !error_q)
    else $error("error not cleared");
  panel_sched_a: assert property (start_q && $past(panel_sw_s)
    && $past(state_q) == st_idle |-> schedule_q == $past(panel_schedule))
    else $error("panel schedule not used");
  idle_none_a: assert property (start_q |-> $past(any_start))
    else $error("start from idle inputs");

  binary_start_c: cover property (idle_go && !parity_fail ##1 start_q);
  parity_reject_c: cover property (idle_go && parity_fail ##1 error_q);
  four_start_c: cover property (start_q && $past(state_q) == st_wait);
  error_cleared_c: cover property ($fell(error_q));
endmodule : weld_start_schedule_decoder

// >>> tb/start_sequencer.sv
`timescale 1ns/1ps
module start_sequencer (
  input wire logic [3:0] code,
  input wire logic bad_parity,
  output sched_pkg::start_pins_t pins
);
  import sched_pkg::*;
  // ***************************************************
  // start pins: code on weights, parity makes count odd unless bad_parity is set or code is zero
  // ***************************************************
  always_comb begin
    pins.weight = code;
    pins.parity = (code != 4'h0) & (~(^code) ^ bad_parity);
  end
endmodule : start_sequencer

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sched_pkg::*;
  localparam int WAIT = 16;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] code = 4'h0;
  logic bad_parity = 1'b0;
  logic error_reset_pin = 1'b0;
  switches_t switches = '0;
  logic [3:0] panel_schedule = 4'h0;
  start_pins_t start_pins;
  logic [3:0] schedule;
  logic start_pulse;
  logic valve1;
  logic valve2;
  logic error;
  logic [7:0] error_code;
  logic seen_pulse;
  logic seen_err;
  int n_mismatch = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  start_sequencer u_seq (.code(code), .bad_parity(bad_parity), .pins(start_pins));

  weld_start_schedule_decoder #(.WAIT_CYCLES(WAIT)) u_dut (
    .clk(clk), .resetn(resetn), .ce(1'b1), .start_pins(start_pins),
    .error_reset_pin(error_reset_pin), .switches(switches),
    .panel_schedule(panel_schedule), .schedule(schedule), .start_pulse(start_pulse),
    .valve1(valve1), .valve2(valve2), .error(error), .error_code(error_code)
  );

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic watch(input int lim, input bit must);
    seen_pulse = 1'b0;
    seen_err = 1'b0;
    for (int i = 0; i < lim && !seen_pulse && !seen_err; i++) begin
      step(1);
      seen_pulse = (start_pulse === 1'b1);
      seen_err = (error === 1'b1);
    end
    if (must && !seen_pulse && !seen_err) begin
      $display("unexpected at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      n_mismatch++;
      close_out();
    end
  endtask : watch

  task automatic setup(input logic par, input logic four, input logic panel);
    switches = '{parity_check_switch: par, four_schedule_switch: four,
                 panel_schedule_switch: panel};
    step(4);
  endtask : setup

  task automatic release_pins;
    code = 4'h0;
    bad_parity = 1'b0;
    step(1);
    chk({7'h0, start_pulse}, 8'h00);
    step(4);
    chk({6'h0, valve1, valve2}, 8'h00);
  endtask : release_pins

  task automatic expect_sel(input logic [3:0] s, input logic v1, input logic v2);
    chk({seen_pulse, seen_err, 2'b0, schedule}, {4'h8, s});
    chk({6'h0, valve1, valve2}, {6'h0, v1, v2});
  endtask : expect_sel

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_idle;
    watch(10, 1'b0);
    chk({7'h0, seen_pulse}, 8'h00);
  endtask : t_idle

  task automatic t_binary;
    setup(1'b1, 1'b0, 1'b0);
    for (int s = 1; s <= 15; s++) begin
      code = s[3:0];
      watch(8, 1'b1);
      expect_sel(s[3:0], s <= 7, s >= 8);
      release_pins();
    end
  endtask : t_binary

  task automatic t_no_parity;
    setup(1'b0, 1'b0, 1'b0);
    code = 4'h3;
    bad_parity = 1'b1;
    watch(8, 1'b1);
    expect_sel(4'h3, 1'b1, 1'b0);
    release_pins();
  endtask : t_no_parity

  task automatic t_parity_err;
    setup(1'b1, 1'b0, 1'b0);
    code = 4'h3;
    bad_parity = 1'b1;
    watch(8, 1'b1);
    chk({6'h0, seen_pulse, seen_err}, 8'h01);
    chk(error_code, 8'h02);
    release_pins();
    chk({7'h0, error}, 8'h01);
    error_reset_pin = 1'b1;
    step(4);
    error_reset_pin = 1'b0;
    chk({7'h0, error}, 8'h00);
    chk(error_code, 8'h00);
  endtask : t_parity_err

  task automatic t_four;
    setup(1'b0, 1'b1, 1'b0);
    code = 4'h4;
    step(4);
    code = 4'h0;
    watch(WAIT + 4, 1'b0);
    chk({7'h0, seen_pulse}, 8'h00);
    code = 4'h4;
    watch(8, 1'b0);
    chk({7'h0, seen_pulse}, 8'h00);
    code = 4'hd;
    watch(WAIT - 6, 1'b0);
    chk({7'h0, seen_pulse}, 8'h00);
    step(1);
    seen_pulse = (start_pulse === 1'b1);
    expect_sel(4'h1, 1'b1, 1'b0);
    release_pins();
  endtask : t_four

  task automatic t_panel;
    setup(1'b1, 1'b0, 1'b1);
    panel_schedule = 4'h9;
    code = 4'h2;
    watch(8, 1'b1);
    expect_sel(4'h9, 1'b0, 1'b1);
    release_pins();
  endtask : t_panel

  initial begin
    step(12);
    resetn = 1'b1;
    step(1);
    chk({schedule, start_pulse, valve1, valve2, error}, 8'h00);
    chk(error_code, 8'h00);
    t_idle();
    t_binary();
    t_no_parity();
    t_parity_err();
    t_four();
    t_panel();
    close_out();
  end
endmodule : tb
